// ---- rtl/frc_cache.sv ----
// ********************************
// flash read cache, ahb-lite slave
// ********************************
module frc_cache
   import frc_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rst_n,
   input  wire logic              ce,
   input  wire logic              cache_mode,
   // flash window slave
   input  wire logic              f_hsel,
   input  wire logic [23:0]       f_haddr,
   input  wire logic [1:0]        f_htrans,
   input  wire logic              f_hwrite,
   input  wire logic              f_hready,
   output logic [WORD_W-1:0]      f_hrdata,
   output logic                   f_hreadyout,
   output logic                   f_hresp,
   // sram window slave, used in mirrored mode
   input  wire logic              m_hsel,
   input  wire logic [13:0]       m_haddr,
   input  wire logic [1:0]        m_htrans,
   input  wire logic              m_hwrite,
   input  wire logic              m_hready,
   input  wire logic [WORD_W-1:0] m_hwdata,
   output logic [WORD_W-1:0]      m_hrdata,
   output logic                   m_hreadyout,
   output logic                   m_hresp,
   // flash link
   output logic                   qspi_sck,
   output logic                   qspi_cs_n,
   output logic [3:0]             qspi_io_o,
   output logic [3:0]             qspi_io_oe_n,
   input  wire logic [3:0]        qspi_io_i
);
   typedef enum logic [3:0] {
      FC_IDLE = 4'b0001,
      FC_LOOK = 4'b0010,
      FC_FILL = 4'b0100,
      FC_ERR  = 4'b1000
   } frc_st_t;

   frc_link_if lk ();

   logic [WORD_W-1:0] mem [SETS*WAYS];      // 16KB backing sram
   logic [TAG_W-1:0]  tag_ff [SETS*WAYS];
   logic [SETS*WAYS-1:0] vld_ff, nxt_vld;
   logic [WAY_W-1:0]  vic_ff [SETS];
   logic [WAY_W-1:0]  nxt_vic;

   frc_st_t           st_ff, nxt_st;
   logic [23:0]       adr_ff, nxt_adr;
   logic [WORD_W-1:0] rd_ff, nxt_rd;
   logic              mode_ff, nxt_mode;
   logic              mw_ff, nxt_mw;
   logic              mt_ff, nxt_mt;     // a transfer is in its data phase
   logic [SRAM_AW-1:0] ma_ff, nxt_ma;

   logic [SET_W-1:0]  set_a;
   logic [TAG_W-1:0]  tag_a;
   logic [WAYS-1:0]   hit_w;
   logic              hit;
   logic [WAY_W-1:0]  hit_idx;
   logic              mem_we;
   logic [SRAM_AW-1:0] mem_wa;
   logic [WORD_W-1:0] mem_wd;

   assign set_a = adr_ff[TAG_LSB-1:SET_LSB];
   assign tag_a = adr_ff[23:TAG_LSB];

   // ********************************
   // tag compare, one per way
   // ********************************
   genvar gw;
   generate
      for (gw = 0; gw < WAYS; gw++) begin : g_way
         assign hit_w[gw] = vld_ff[{set_a, WAY_W'(gw)}] &&
                            tag_ff[{set_a, WAY_W'(gw)}] == tag_a;
      end
   endgenerate

   always_comb begin
      hit_idx = '0;
      for (int i = 0; i < WAYS; i++) begin
         if (hit_w[i]) hit_idx = WAY_W'(i);
      end
   end
   assign hit = |hit_w;

   // ********************************
   // lookup and fill control
   // ********************************
   always_comb begin
      nxt_st   = st_ff;
      nxt_adr  = adr_ff;
      nxt_rd   = rd_ff;
      nxt_vld  = vld_ff;
      nxt_mode = mode_ff;
      nxt_vic  = vic_ff[set_a];
      mem_we   = 1'b0;
      mem_wa   = {set_a, vic_ff[set_a]};
      mem_wd   = lk.data;
      case (st_ff)
         FC_IDLE: begin
            // mode changes only between transfers; leaving cache mode drops all lines
            nxt_mode = cache_mode;
            if (!cache_mode) nxt_vld = '0;
            if (f_hsel && f_hready && f_htrans[1]) begin
               nxt_adr = f_haddr;
               // writes and disabled-mode fetches are refused
               if (f_hwrite || !mode_ff) nxt_st = FC_ERR;
               else nxt_st = FC_LOOK;
            end
         end
         FC_LOOK: begin
            if (hit) begin
               nxt_rd = mem[{set_a, hit_idx}];
               nxt_st = FC_IDLE;
            end else begin
               nxt_st = FC_FILL;
            end
         end
         FC_FILL: begin
            if (lk.done) begin
               mem_we  = 1'b1;
               nxt_vld[{set_a, vic_ff[set_a]}] = 1'b1;
               nxt_vic = vic_ff[set_a] + WAY_W'(1); // round robin victim
               nxt_rd  = lk.data;
               nxt_st  = FC_IDLE;
            end
         end
         FC_ERR:  nxt_st = FC_IDLE;
         default: nxt_st = FC_IDLE;
      endcase
      // mirrored mode: bus writes into sram instead
      if (!mode_ff && mw_ff) begin
         mem_we = 1'b1;
         mem_wa = ma_ff;
         mem_wd = m_hwdata;
      end
   end

   // hit answer data comes out two cycles after the address phase, after one lookup wait cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff   <= FC_IDLE;
         adr_ff  <= 24'h00_0000;
         rd_ff   <= 32'h0000_0000;
         vld_ff  <= '0;
         mode_ff <= 1'b0;
      end else if (ce) begin
         st_ff   <= nxt_st;
         adr_ff  <= nxt_adr;
         rd_ff   <= nxt_rd;
         vld_ff  <= nxt_vld;
         mode_ff <= nxt_mode;
      end
   end

   // storage arrays carry no reset; valid bits guard them
   always_ff @(posedge mclk) begin
      if (ce && mem_we) mem[mem_wa] <= mem_wd;
      if (ce && st_ff == FC_FILL && lk.done) begin
         tag_ff[{set_a, vic_ff[set_a]}] <= tag_a;
      end
   end

   // victim pointers reset: an unknown way would make the first fill of a set land nowhere
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < SETS; i++) begin
            vic_ff[i] <= '0;
         end
      end else if (ce && st_ff == FC_FILL && lk.done) begin
         vic_ff[set_a] <= nxt_vic;
      end
   end

   // ********************************
   // mirrored-mode memory slave
   // ********************************
   always_comb begin
      nxt_mw = 1'b0;
      nxt_mt = 1'b0;
      nxt_ma = ma_ff;
      if (m_hsel && m_hready && m_htrans[1]) begin
         nxt_mw = m_hwrite;
         nxt_mt = 1'b1;
         nxt_ma = m_haddr[13:ADDR_LSB];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mw_ff <= 1'b0;
         mt_ff <= 1'b0;
         ma_ff <= '0;
      end else if (ce) begin
         mw_ff <= nxt_mw;
         mt_ff <= nxt_mt;
         ma_ff <= nxt_ma;
      end
   end

   // reserved in cached mode: error answer, no data
   assign m_hrdata    = mode_ff ? 32'h0000_0000 : mem[ma_ff];
   assign m_hreadyout = 1'b1;
   // refusal answers in the data phase of every taken read or write while in cached mode
   assign m_hresp     = mode_ff && mt_ff;

   // ********************************
   // flash window answer
   // ********************************
   assign f_hrdata    = rd_ff;
   assign f_hreadyout = (st_ff == FC_IDLE);
   assign f_hresp     = (st_ff == FC_ERR);

   assign lk.req  = (st_ff == FC_FILL);
   assign lk.addr = {adr_ff[23:ADDR_LSB], 2'h0};

   frc_qspi u_qspi (
      .mclk         (mclk),
      .rst_n        (rst_n),
      .ce           (ce),
      .lk           (lk.eng),
      .qspi_sck     (qspi_sck),
      .qspi_cs_n    (qspi_cs_n),
      .qspi_io_o    (qspi_io_o),
      .qspi_io_oe_n (qspi_io_oe_n),
      .qspi_io_i    (qspi_io_i)
   );
endmodule : frc_cache

// ---- shared/frc_pkg.sv ----
package frc_pkg;
   // ********************************
   // geometry
   // ********************************
   localparam int unsigned SRAM_BYTES  = 16384;            // backing store, 16KB
   localparam int unsigned WAYS        = 4;
   localparam int unsigned WAY_W       = 2;
   localparam int unsigned WORD_W      = 32;
   localparam int unsigned SETS        = SRAM_BYTES / 4 / WAYS;
   localparam int unsigned SET_W       = 10;
   localparam int unsigned TAG_W       = 24 - SET_W - 2;   // flash window is 16MB
   localparam int unsigned SRAM_AW     = SET_W + WAY_W;
   localparam int unsigned ADDR_LSB    = 2;
   localparam int unsigned SET_LSB     = ADDR_LSB;
   localparam int unsigned TAG_LSB     = SET_LSB + SET_W;
   // ********************************
   // quad-spi link
   // ********************************
   localparam logic [7:0] CMD_QREAD    = 8'hEB;            // fast read quad i/o
   localparam logic [7:0] MODE_BITS    = 8'h00;
   localparam int unsigned DUMMY_CLKS  = 4;
   localparam int unsigned CMD_CLKS    = 8;
   localparam int unsigned ADDR_CLKS   = 8;                // 24 addr + 8 mode bits, 4 wide
   localparam int unsigned DATA_CLKS   = 8;
   localparam int unsigned SCK_HALF    = 4;                // mclk cycles per sck half period
   localparam logic [5:0]  PH_W0       = 6'h00;
   // running sck edge counts at which each phase starts
   localparam logic [5:0]  PH_ADDR     = 6'(CMD_CLKS);
   localparam logic [5:0]  PH_DUMMY    = 6'(CMD_CLKS + ADDR_CLKS);
   localparam logic [5:0]  PH_DATA     = 6'(CMD_CLKS + ADDR_CLKS + DUMMY_CLKS);
   localparam logic [5:0]  PH_END      = 6'(CMD_CLKS + ADDR_CLKS + DUMMY_CLKS + DATA_CLKS);
   // ahb htrans
   localparam logic [1:0]  HT_NONSEQ   = 2'h2;
endpackage : frc_pkg

// ---- shared/frc_link_if.sv ----
// carries a word request and answer between cache core and link engine
interface frc_link_if;
   import frc_pkg::*;
   logic              req;
   logic [23:0]       addr;
   logic              done;
   logic [WORD_W-1:0] data;
   modport core (output req, output addr, input done, input data);
   modport eng  (input req, input addr, output done, output data);
endinterface : frc_link_if

// ---- rtl/frc_qspi.sv ----
// quad-spi read engine; sck made here by dividing mclk
module frc_qspi
   import frc_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   frc_link_if.eng         lk,
   output logic            qspi_sck,
   output logic            qspi_cs_n,
   output logic [3:0]      qspi_io_o,
   output logic [3:0]      qspi_io_oe_n,
   input  wire logic [3:0] qspi_io_i
);
   typedef enum logic [1:0] {
      FQ_IDLE = 2'b01,
      FQ_RUN  = 2'b10
   } frc_qs_t;

   frc_qs_t           st_ff, nxt_st;
   logic [2:0]        div_ff, nxt_div;
   logic              sck_ff, nxt_sck;
   logic [5:0]        cnt_ff, nxt_cnt;
   logic [39:0]       sh_ff, nxt_sh;     // cmd then addr+mode, shifted out msb first
   logic [WORD_W-1:0] rx_ff, nxt_rx;
   logic              done_ff, nxt_done;
   logic [3:0]        s1_ff, s2_ff, s3_ff; // io input resync

   // ********************************
   // next state
   // ********************************
   always_comb begin
      nxt_st   = st_ff;
      nxt_div  = div_ff;
      nxt_sck  = sck_ff;
      nxt_cnt  = cnt_ff;
      nxt_sh   = sh_ff;
      nxt_rx   = rx_ff;
      nxt_done = 1'b0;
      case (st_ff)
         FQ_IDLE: begin
            nxt_sck = 1'b0;
            if (lk.req && !done_ff) begin
               nxt_st  = FQ_RUN;
               nxt_cnt = PH_W0;
               nxt_div = 3'h0;
               // command sent 1 bit per clock on io0 only; address and mode follow as 4-bit nibbles
               nxt_sh  = {CMD_QREAD, lk.addr, MODE_BITS};
            end
         end
         FQ_RUN: begin
            nxt_div = div_ff + 3'h1;
            if (div_ff == 3'(SCK_HALF - 1)) begin
               nxt_div = 3'h0;
               nxt_sck = ~sck_ff;
               if (!sck_ff) begin
                  // rising edge: sample data nibbles; s3_ff when s2_ff agrees, else s2_ff
                  if (cnt_ff >= PH_DATA && s2_ff == s3_ff) nxt_rx = {rx_ff[27:0], s3_ff};
                  else if (cnt_ff >= PH_DATA) nxt_rx = {rx_ff[27:0], s2_ff};
               end else begin
                  // falling edge: advance output
                  nxt_cnt = cnt_ff + 6'h1;
                  if (cnt_ff < PH_ADDR) nxt_sh = {sh_ff[38:0], 1'b0};
                  else                  nxt_sh = {sh_ff[35:0], 4'h0};
                  if (cnt_ff + 6'h1 == PH_END) begin
                     nxt_st   = FQ_IDLE;
                     nxt_done = 1'b1;
                  end
               end
            end
         end
         default: nxt_st = FQ_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff   <= FQ_IDLE;
         div_ff  <= 3'h0;
         sck_ff  <= 1'b0;
         cnt_ff  <= 6'h00;
         sh_ff   <= 40'h00_0000_0000;
         rx_ff   <= 32'h0000_0000;
         done_ff <= 1'b0;
         s1_ff   <= 4'h0;
         s2_ff   <= 4'h0;
         s3_ff   <= 4'h0;
      end else if (ce) begin
         st_ff   <= nxt_st;
         div_ff  <= nxt_div;
         sck_ff  <= nxt_sck;
         cnt_ff  <= nxt_cnt;
         sh_ff   <= nxt_sh;
         rx_ff   <= nxt_rx;
         done_ff <= nxt_done;
         s1_ff   <= qspi_io_i;
         s2_ff   <= s1_ff;
         s3_ff   <= s2_ff;
      end
   end

   // ********************************
   // pins
   // ********************************
   // command phase single-bit on io0, address phase 4 bits, then released
   always_comb begin
      qspi_io_o    = 4'h0;
      qspi_io_oe_n = 4'hF;
      if (st_ff == FQ_RUN && cnt_ff < PH_ADDR) begin
         qspi_io_o    = {3'h0, sh_ff[39]};
         qspi_io_oe_n = 4'hE;
      end else if (st_ff == FQ_RUN && cnt_ff < PH_DUMMY) begin
         qspi_io_o    = sh_ff[39:36];
         qspi_io_oe_n = 4'h0;
      end
   end
   assign qspi_sck  = sck_ff;
   assign qspi_cs_n = (st_ff != FQ_RUN);
   assign lk.done   = done_ff;
   assign lk.data   = rx_ff;
endmodule : frc_qspi

// ---- sim/frc_flash_model.sv ----
// ****
// serial flash read model
// ****
module frc_flash_model
   import frc_pkg::*;
(
   input  wire logic       qspi_sck,
   input  wire logic       qspi_cs_n,
   input  wire logic [3:0] qspi_io_o,
   input  wire logic [3:0] qspi_io_oe_n,
   output logic [3:0]      qspi_io_i,
   output logic [7:0]      cmd,
   output logic [23:0]     addr
);
   timeunit 1ns;
   timeprecision 1ns;
   int          n   = 0;
   logic        drv = 1'h0;
   logic [3:0]  nib = 4'h0;
   logic [31:0] w;
   // undriven bits show the inverse of the last nibble, never a stale copy
   assign qspi_io_i = drv ? nib : (~qspi_io_oe_n & qspi_io_o) | (qspi_io_oe_n & ~nib);
   // a new frame restarts the edge count
   always @(negedge qspi_cs_n) begin
      n = 0;
   end
   // command on io0, then address nibbles msb first
   always @(posedge qspi_sck) begin
      if (!qspi_cs_n) begin
         if (n < 8)
            cmd = {cmd[6:0], qspi_io_o[0]};
         else if (n < 14)
            addr = {addr[19:0], qspi_io_o};
         n++;
      end
   end
   // data changes on the fall so it is settled at the next rise
   always @(negedge qspi_sck) begin
      drv = !qspi_cs_n && n >= 20 && n < 28;
      w   = {addr[23:2], 2'h0, addr[9:2]};
      if (drv)
         nib = 4'(w >> (4 * (27 - n)));
   end
endmodule : frc_flash_model

// ---- sim/frc_cache_sva.sv ----
// ****
// flash read cache checker
// ****
module frc_cache_sva
   import frc_pkg::*;
(
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic       cache_mode,
   input wire logic       f_hsel,
   input wire logic [1:0] f_htrans,
   input wire logic       f_hwrite,
   input wire logic       f_hreadyout,
   input wire logic       f_hresp,
   input wire logic       m_hsel,
   input wire logic [1:0] m_htrans,
   input wire logic       m_hresp,
   input wire logic       qspi_sck,
   input wire logic       qspi_cs_n,
   input wire logic [3:0] qspi_io_o,
   input wire logic [3:0] qspi_io_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] edges_ff, nxt_edges;
   logic       sck_ff, nxt_sck;
   logic       f_take, m_take, rise, rd_c;
   assign f_take = f_hsel && f_htrans[1] && f_hreadyout;
   assign m_take = m_hsel && m_htrans[1];
   assign rise   = qspi_sck && !sck_ff;
   assign rd_c   = f_take && !f_hwrite && cache_mode;
   // sck rises since select fell
   always_comb begin
      nxt_sck   = qspi_sck;
      nxt_edges = qspi_cs_n ? 6'h00 : edges_ff + 6'(rise);
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         edges_ff <= 6'h00;
         sck_ff   <= 1'h0;
      end else begin
         edges_ff <= nxt_edges;
         sck_ff   <= nxt_sck;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_write_refused: assert property (
      f_take && f_hwrite |-> ##[1:2] f_hresp) else $error("flash write accepted");
   a_hit_look: assert property (
      rd_c |=> !f_hreadyout) else $error("no lookup wait");
   a_miss_bound: assert property (
      rd_c |-> ##[2:400] f_hreadyout) else $error("read never completed");
   a_mirror_err: assert property (
      f_take && !cache_mode |-> ##[1:2] f_hresp) else $error("flash open in mirrored mode");
   a_sram_free: assert property (
      m_take && !cache_mode |=> !m_hresp) else $error("sram refused in mirrored mode");
   a_sram_held: assert property (
      m_take && cache_mode |-> ##[0:1] m_hresp) else $error("sram open in cached mode");
   a_fetch_cause: assert property (
      $fell(qspi_cs_n) |-> !f_hreadyout && cache_mode) else $error("stray flash frame");
   a_cmd_bits: assert property (
      rise && edges_ff < PH_ADDR |-> qspi_io_oe_n == 4'hE
         && qspi_io_o[0] == CMD_QREAD[3'h7 - edges_ff[2:0]]) else $error("bad command bit");
   a_frame_len: assert property (
      $rose(qspi_cs_n) |-> edges_ff == PH_END) else $error("bad frame length");
   a_link_idle: assert property (
      qspi_cs_n |-> !qspi_sck && qspi_io_oe_n == 4'hF) else $error("link busy while idle");
   c_hit: cover property (rd_c ##1 !f_hreadyout ##1 f_hreadyout);
   c_fill: cover property ($rose(qspi_cs_n));
   c_mirror: cover property (m_take && !cache_mode);
endmodule : frc_cache_sva
bind frc_cache frc_cache_sva frc_cache_sva_i (.*);

// ---- sim/flash_read_cache_tb.sv ----
module flash_read_cache_tb
   import frc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 0, rst_n = 0, ce = 1, cache_mode = 0;
   logic        f_hsel = 0, f_hwrite = 0, f_hready = 1;
   logic        m_hsel = 0, m_hwrite = 0, m_hready = 1;
   logic [1:0]  f_htrans = 2'h0, m_htrans = 2'h0;
   logic [23:0] f_haddr = 24'h0, fm_addr;
   logic [13:0] m_haddr = 14'h0;
   logic [31:0] m_hwdata = 32'h0, f_hrdata, m_hrdata;
   logic        f_hreadyout, f_hresp, m_hreadyout, m_hresp, qspi_sck, qspi_cs_n;
   logic [3:0]  qspi_io_o, qspi_io_oe_n, qspi_io_i;
   logic [7:0]  fm_cmd;
   logic [15:0] rnd = 16'h0016;
   int          failures = 0, cmp_count = 0;
   bit          vld [int];
   logic [31:0] sref [int];
   frc_cache frc_cache_i (.*);
   frc_flash_model frc_flash_model_i (.qspi_sck, .qspi_cs_n, .qspi_io_o, .qspi_io_oe_n,
      .qspi_io_i, .cmd(fm_cmd), .addr(fm_addr));
   // ****
   // helpers
   // ****
   initial begin
      forever #5 mclk = ~mclk;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude
   // one flash window transfer; hit or miss predicted from the line list
   task automatic frd(input logic [23:0] a, input logic wr);
      logic r;
      int   w;
      logic hit;
      hit      = cache_mode && !wr && vld.exists(int'(a[23:2]));
      f_hsel   = 1'h1;
      f_htrans = HT_NONSEQ;
      f_haddr  = a;
      f_hwrite = wr;
      r        = 1'h0;
      w        = 0;
      @(negedge mclk);
      f_hsel   = 1'h0;
      f_htrans = 2'h0;
      while (f_hreadyout !== 1'h1 && w < 600) begin
         r |= f_hresp;
         w++;
         @(negedge mclk);
      end
      r |= f_hresp;
      if (wr) begin
         chk(32'(r), 32'h1);
      end else if (!cache_mode) begin
         chk(32'(r), 32'h1);
      end else begin
         chk(32'(r), 32'h0);
         chk(32'(w < 600), 32'h1);
         chk(f_hrdata, {a[23:2], 2'h0, a[9:2]});
         chk(32'(w == 1), 32'(hit));
         if (!hit)
            chk({fm_cmd, fm_addr}, {CMD_QREAD, a[23:2], 2'h0});
         vld[int'(a[23:2])] = 1'b1;
      end
   endtask : frd
   // one sram window transfer, data phase checked at once
   task automatic mx(input logic [13:0] a, input logic wr, input logic [31:0] wd);
      m_hsel   = 1'h1;
      m_htrans = HT_NONSEQ;
      m_haddr  = a;
      m_hwrite = wr;
      @(negedge mclk);
      m_hsel   = 1'h0;
      m_htrans = 2'h0;
      m_hwdata = wd;
      chk(32'(m_hreadyout), 32'h1);
      if (cache_mode) begin
         chk(32'(m_hresp), 32'h1);
      end else begin
         chk(32'(m_hresp), 32'h0);
         if (wr)
            sref[int'(a[13:2])] = wd;
         else
            chk(m_hrdata, sref[int'(a[13:2])]);
      end
      // one idle cycle keeps the write data up and parts two requests
      @(negedge mclk);
   endtask : mx
   // mode changes only while idle; mirrored drops every line
   task automatic setm(input logic m);
      cache_mode = m;
      if (!m)
         vld.delete();
      repeat (2) @(negedge mclk);
   endtask : setm
   // ****
   // scenarios
   // ****
   initial begin
      logic [23:0] a;
      logic [9:0]  s;
      logic [11:0] tg;
      repeat (5) @(posedge mclk);
      @(negedge mclk);
      rst_n = 1'h1;
      @(negedge mclk);
      frd(24'h000100, 1'h0);
      rnd = lfsr(rnd);
      s   = rnd[9:0];
      tg  = rnd[15:4];
      for (int k = 0; k < 8; k++) begin
         rnd = lfsr(rnd);
         mx({k[1:0], s, 2'h0}, 1'(k < 4), {rnd, ~rnd});
      end
      setm(1'h1);
      mx(14'h0010, 1'h0, 32'h0);
      // four tags in one set miss, then all four hit
      for (int k = 0; k < 8; k++) begin
         frd({tg + 12'(k[1:0]), s, 2'h0}, 1'h0);
      end
      // other sets keep the four-way set intact
      for (int k = 0; k < 6; k++) begin
         rnd = lfsr(lfsr(rnd));
         a   = {rnd[15:4], ~s[9], rnd[8:0], 2'h0};
         frd(a, 1'h0);
         frd(a, 1'h0);
      end
      a = {tg, s, 2'h0};
      frd(a, 1'h1);
      frd(a, 1'h0);
      setm(1'h0);
      frd(a, 1'h0);
      setm(1'h1);
      // freezing the clock enable mid-fill must only stretch the miss
      fork
         frd(a, 1'h0);
         begin
            repeat (40) @(negedge mclk);
            ce = 1'h0;
            repeat (20) @(negedge mclk);
            ce = 1'h1;
         end
      join
      conclude();
   end
   // a hung handshake ends the run; about eleven fills fit well inside
   initial begin
      repeat (40000) @(posedge mclk);
      failures++;
      conclude();
   end
endmodule : flash_read_cache_tb
